// >>> lbc_config_regs.sv
/*
 * Configuration register bank of the LPC bridge function with shutdown
 * init, error NMI, LPC sync error flag and subtractive routing.
 * Assumes the primary bus target logic presents one-cycle config
 * read/write strobes already in the clock domain; error pins and
 * secondary devsel come from outside; the error status pin and secondary devsel are synchronised here, lpc_sync_error is used as is.
 */
`timescale 1ns/10ps

module lbc_config_regs
    import lbc_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cfg_read,
    input wire logic cfg_write,
    input wire logic [4:0] cfg_device,
    input wire logic [2:0] cfg_function,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_hit,
    input wire logic shutdown_cycle,
    output logic cpu_init,
    input wire logic lpc_sync_error,
    input wire logic error_status_pin,
    output logic nmi,
    input wire logic unclaimed_cycle,
    input wire logic sec_devsel_l,
    input wire logic lpc_done,
    output logic sec_start,
    output logic sub_devsel_oe,
    output logic sub_trdy_oe,
    output logic lpc_start,
    output logic route_busy
);

    logic shutdown_cycle_reset_enable; // Command bit 3
    logic error_nmi_enable; // IO control bit 7
    logic lpc_sync_error_flag; // IO control bit 6, sticky
    logic secondary_first_subtractive; // IO control bit 5
    logic [15:0] bridge_subsystem_ident; // Bridge_subsystem_ident field
    logic [15:0] subsystem_vendor_field; // Subsystem vendor field
    logic [31:0] next_rdata; // Read mux result
    logic sel; // Access aimed at this function
    logic wr_ioctl; // Write hitting IO control byte
    logic wr_alias; // Write hitting subsystem alias
    logic err_sync; // Synchronised error status
    logic err_prev; // Previous error status for edge
    logic devsel_seen; // Synchronised secondary devsel, high when claimed
    logic [23:0] class_code_field; // Class code

    // Class code constant
    assign class_code_field = LBC_CLASS_ISA;

    // Function select
    assign sel = (cfg_device == LBC_DEV_NUM) && (cfg_function == LBC_FUNC_NUM);
    assign cfg_hit = sel && (cfg_read || cfg_write);
    assign wr_ioctl = sel && cfg_write && (cfg_offset == LBC_OFS_IOCTL1) && cfg_byte_en[0];
    assign wr_alias = sel && cfg_write && (cfg_offset == LBC_OFS_SUBSYS_ALIAS);

    // Input synchronisers
    lbc_sync u_err_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(error_status_pin),
        .sync_out(err_sync)
    );

    lbc_sync u_devsel_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(~sec_devsel_l),
        .sync_out(devsel_seen)
    );

    // Shutdown cycle reset enable, only writable bit of command
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shutdown_cycle_reset_enable <= LBC_STSCMD_RST[LBC_CMD_SPCYC_BIT];
        end else if (sel && cfg_write && (cfg_offset == LBC_OFS_STSCMD) && cfg_byte_en[0]) begin
            shutdown_cycle_reset_enable <= cfg_wdata[LBC_CMD_SPCYC_BIT];
        end
    end

    // IO control enables
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            error_nmi_enable <= LBC_IOCTL1_RST[LBC_IO1_NMI_BIT];
            secondary_first_subtractive <= LBC_IOCTL1_RST[LBC_IO1_SECONDARY_FIRST_SUBTRACTIVE_BIT];
        end else if (wr_ioctl) begin
            error_nmi_enable <= cfg_wdata[LBC_IO1_NMI_BIT];
            secondary_first_subtractive <= cfg_wdata[LBC_IO1_SECONDARY_FIRST_SUBTRACTIVE_BIT];
        end
    end

    // Sticky LPC sync error; a new error wins over the clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lpc_sync_error_flag <= LBC_IOCTL1_RST[LBC_IO1_LPC_SYNC_ERROR_FLAG_BIT];
        end else if (lpc_sync_error) begin
            lpc_sync_error_flag <= 1'b1;
        end else if (wr_ioctl && cfg_wdata[LBC_IO1_LPC_SYNC_ERROR_FLAG_BIT]) begin
            lpc_sync_error_flag <= 1'b0;
        end
    end

    // Subsystem fields, loaded only through the alias
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bridge_subsystem_ident <= LBC_SUBSYS_RST[31:16];
            subsystem_vendor_field <= LBC_SUBSYS_RST[15:0];
        end else if (wr_alias) begin
            if (cfg_byte_en[0]) begin
                subsystem_vendor_field[7:0] <= cfg_wdata[7:0];
            end
            if (cfg_byte_en[1]) begin
                subsystem_vendor_field[15:8] <= cfg_wdata[15:8];
            end
            if (cfg_byte_en[2]) begin
                bridge_subsystem_ident[7:0] <= cfg_wdata[23:16];
            end
            if (cfg_byte_en[3]) begin
                bridge_subsystem_ident[15:8] <= cfg_wdata[31:24];
            end
        end
    end

    // Processor init on shutdown special cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpu_init <= 1'b0;
        end else begin
            cpu_init <= shutdown_cycle && shutdown_cycle_reset_enable;
        end
    end

    // NMI on rising error status or LPC error set
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            err_prev <= 1'b0;
            nmi <= 1'b0;
        end else begin
            err_prev <= err_sync;
            nmi <= error_nmi_enable && ((err_sync && !err_prev) || lpc_sync_error);
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (cfg_offset)
            LBC_OFS_IDENT: next_rdata = {DEVICE_CODE, VENDOR_CODE};
            LBC_OFS_STSCMD: next_rdata = {LBC_STSCMD_RST[31:4],
                shutdown_cycle_reset_enable, 3'h7};
            LBC_OFS_CLASSREV: next_rdata = {class_code_field, REVISION};
            LBC_OFS_HDRMISC: next_rdata = LBC_HDRMISC_RST;
            LBC_OFS_SUBSYS: next_rdata = {bridge_subsystem_ident, subsystem_vendor_field};
            LBC_OFS_IOCTL1: next_rdata = {24'h000000, error_nmi_enable, lpc_sync_error_flag,
                secondary_first_subtractive, 5'h00};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Registered read data
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= 32'h00000000;
        end else if (sel && cfg_read) begin
            cfg_rdata <= next_rdata;
        end
    end

    // Unclaimed cycle routing
    lbc_router u_router (
        .clock(clock),
        .rst_b(rst_b),
        .unclaimed_cycle(unclaimed_cycle),
        .secondary_first(secondary_first_subtractive),
        .sec_devsel_seen(devsel_seen),
        .lpc_done(lpc_done),
        .sec_start(sec_start),
        .sub_devsel_oe(sub_devsel_oe),
        .sub_trdy_oe(sub_trdy_oe),
        .lpc_start(lpc_start),
        .route_busy(route_busy)
    );

endmodule

// >>> lbc_config_regs_chk.sv
/* Port assertions for the LPC bridge config bank.
   Assumes it is bound into lbc_config_regs. */
`timescale 1ns/10ps
module lbc_config_regs_chk
    import lbc_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h1234,
    parameter logic [15:0] DEVICE_CODE = 16'h5678,
    parameter logic [7:0] REVISION = 8'h01
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cfg_read,
    input wire logic cfg_write,
    input wire logic [4:0] cfg_device,
    input wire logic [2:0] cfg_function,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_hit,
    input wire logic shutdown_cycle,
    input wire logic cpu_init,
    input wire logic lpc_sync_error,
    input wire logic nmi,
    input wire logic unclaimed_cycle,
    input wire logic sec_devsel_l,
    input wire logic sec_start,
    input wire logic sub_devsel_oe,
    input wire logic sub_trdy_oe,
    input wire logic lpc_start,
    input wire logic route_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic rd; // Hit read taken this cycle
    logic spc_en; // Shadow of shutdown enable
    logic nmi_en; // Shadow of NMI enable
    logic sub_en; // Shadow of subtractive enable
    assign rd = cfg_read && cfg_hit;
    // Shadow the control bits from hit writes of byte 0
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            spc_en <= 1'b1;
            nmi_en <= 1'b0;
            sub_en <= 1'b0;
        end else if (cfg_write && cfg_hit && cfg_byte_en[0]) begin
            if (cfg_offset == LBC_OFS_STSCMD) spc_en <= cfg_wdata[3];
            if (cfg_offset == LBC_OFS_IOCTL1) begin
                nmi_en <= cfg_wdata[7];
                sub_en <= cfg_wdata[5];
            end
        end
    end
    sequence claim_s; sub_devsel_oe && sub_trdy_oe; endsequence
    sequence replay_s; !sub_devsel_oe && lpc_start; endsequence
    chk_hit_decode: assert property (cfg_hit == ((cfg_read || cfg_write) &&
        cfg_device == LBC_DEV_NUM && cfg_function == LBC_FUNC_NUM)) else $error("bad hit");
    chk_ident_ro: assert property (rd && cfg_offset == LBC_OFS_IDENT |=>
        cfg_rdata == {DEVICE_CODE, VENDOR_CODE}) else $error("bad ident");
    chk_stscmd_fixed: assert property (rd && cfg_offset == LBC_OFS_STSCMD |=>
        cfg_rdata[31:4] == LBC_STSCMD_RST[31:4] && cfg_rdata[2:0] == 3'h7) else $error("bad cmd");
    chk_class_ro: assert property (rd && cfg_offset == LBC_OFS_CLASSREV |=>
        cfg_rdata == {LBC_CLASS_ISA, REVISION}) else $error("bad class");
    chk_hdr_ro: assert property (rd && cfg_offset == LBC_OFS_HDRMISC |=>
        cfg_rdata == LBC_HDRMISC_RST) else $error("bad header");
    chk_init_gate: assert property (shutdown_cycle |=> cpu_init == $past(spc_en))
        else $error("bad init");
    chk_nmi_lpc: assert property (lpc_sync_error && nmi_en |=> nmi) else $error("no nmi");
    chk_direct_lpc: assert property (unclaimed_cycle && !sub_en && !route_busy |=>
        lpc_start && !sec_start) else $error("no direct replay");
    chk_claim_replay: assert property ($rose(sub_devsel_oe) |-> claim_s ##1 replay_s)
        else $error("bad claim");
    chk_devsel_owns: assert property ($fell(sec_devsel_l) |->
        (!sub_devsel_oe && !lpc_start) [*6]) else $error("claimed owned cycle");
endmodule

// >>> lbc_config_regs_tb.sv
/* Self-checking bench for the config bank and its router.
   Assumes the checker and far-side model are compiled first. */
`timescale 1ns/10ps
module lbc_config_regs_tb;
    import lbc_pkg::*;
    logic clock = 0, rst_b = 0, cfg_read = 0, cfg_write = 0, claim = 0;
    logic shutdown_cycle = 0, lpc_sync_error = 0, error_status_pin = 0, unclaimed_cycle = 0;
    logic [4:0] cfg_device = 5'h01;
    logic [2:0] cfg_function = 3'h0;
    logic [7:0] cfg_offset = 8'h00, ro[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h2c};
    logic [3:0] cfg_byte_en = 4'hf;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, v, exp_q[$], msk_q[$];
    logic cfg_hit, cpu_init, nmi, sec_start, sub_devsel_oe, sub_trdy_oe, lpc_start;
    logic route_busy, sec_devsel_l, lpc_done, rd_d = 0;
    logic [31:0] xr[3] = '{32'h1, 32'hf, 32'h8}; // Expected route flags per case
    int n_fail = 0, comparisons = 0, cycles = 0;
    logic [31:0] seen;
    integer seed = 32'h9d56041f;
    always #12.5 clock = ~clock;
    // Codes below are arbitrary
    lbc_config_regs #(.VENDOR_CODE(16'h1a2b), .DEVICE_CODE(16'h3c4d), .REVISION(8'h5e)) dut (
        .clock, .rst_b, .cfg_read, .cfg_write, .cfg_device, .cfg_function, .cfg_offset,
        .cfg_byte_en, .cfg_wdata, .cfg_rdata, .cfg_hit, .shutdown_cycle, .cpu_init,
        .lpc_sync_error, .error_status_pin, .nmi, .unclaimed_cycle, .sec_devsel_l, .lpc_done,
        .sec_start, .sub_devsel_oe, .sub_trdy_oe, .lpc_start, .route_busy);
    lbc_far_side far (.clock, .rst_b, .claim, .sec_start, .lpc_start, .sec_devsel_l, .lpc_done);
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] o, input logic [31:0] d, input logic [3:0] be);
        @(negedge clock);
        {cfg_write, cfg_offset, cfg_wdata, cfg_byte_en} = {1'b1, o, d, be};
        @(negedge clock);
        cfg_write = 0;
    endtask
    task automatic rd(input logic [7:0] o, input logic [31:0] e, m);
        @(negedge clock);
        exp_q.push_back(e);
        msk_q.push_back(m);
        {cfg_read, cfg_offset} = {1'b1, o};
        @(negedge clock);
        cfg_read = 0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock) s = 1;
        @(negedge clock) s = 0;
    endtask
    // Compare each hit read with the oldest note; cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles > 2000) begin
            n_fail++;
            results();
        end else begin
            if (rd_d) chk("cfg_rdata", cfg_rdata & msk_q.pop_front(), exp_q.pop_front());
            rd_d <= cfg_read && cfg_hit;
        end
    end
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1;
        // Reset values, then random writes to fixed fields, then reread
        repeat (2) begin
            rd(LBC_OFS_IDENT, 32'h3c4d1a2b, '1);
            rd(LBC_OFS_STSCMD, LBC_STSCMD_RST, '1);
            rd(LBC_OFS_CLASSREV, {LBC_CLASS_ISA, 8'h5e}, '1);
            rd(LBC_OFS_HDRMISC, LBC_HDRMISC_RST, '1);
            rd(LBC_OFS_SUBSYS, LBC_SUBSYS_RST, '1);
            rd(LBC_OFS_IOCTL1, 32'h0, 32'hff);
            foreach (ro[i]) wr(ro[i], $random(seed) | 32'h8, 4'hf);
        end
        v = $random(seed);
        wr(LBC_OFS_SUBSYS_ALIAS, v, 4'hf);
        rd(LBC_OFS_SUBSYS, v, '1);
        // Another device number must not hit
        @(negedge clock) {cfg_read, cfg_device} = {1'b1, 5'h02};
        #1 chk("cfg_hit", cfg_hit, 0);
        @(negedge clock) {cfg_read, cfg_device} = {1'b0, 5'h01};
        for (int en = 1; en >= 0; en--) begin
            wr(LBC_OFS_STSCMD, {28'h0000000, en[0], 3'h0}, 4'h1);
            pulse(shutdown_cycle);
            chk("cpu_init", cpu_init, en[0]);
            rd(LBC_OFS_STSCMD, {LBC_STSCMD_RST[31:4], en[0], 3'h7}, '1);
        end
        // Sticky sync error flag and NMI gating
        pulse(lpc_sync_error);
        chk("nmi off", nmi, 0);
        wr(LBC_OFS_IOCTL1, 32'h80, 4'h1);
        pulse(lpc_sync_error);
        chk("nmi", nmi, 1);
        wr(LBC_OFS_IOCTL1, 32'h80, 4'h1);
        rd(LBC_OFS_IOCTL1, 32'hc0, 32'hff);
        wr(LBC_OFS_IOCTL1, 32'hc0, 4'h1);
        rd(LBC_OFS_IOCTL1, 32'h80, 32'hff);
        @(negedge clock) error_status_pin = 1;
        seen = 0;
        repeat (8) @(negedge clock) seen |= nmi;
        chk("nmi pin", seen, 1);
        // Routing: direct, secondary then claim, secondary owner
        for (int c = 0; c < 3; c++) begin
            wr(LBC_OFS_IOCTL1, {26'h0000000, c != 0, 5'h00}, 4'h1);
            claim = (c == 2);
            @(negedge clock) unclaimed_cycle = 1;
            #1 seen = {sec_start, sub_devsel_oe, sub_trdy_oe, lpc_start};
            repeat (24) @(negedge clock) begin
                unclaimed_cycle = 0;
                seen |= {sec_start, sub_devsel_oe, sub_trdy_oe, lpc_start};
            end
            chk("route", seen, xr[c]);
            chk("route_busy", route_busy, 0);
        end
        results();
    end
endmodule
bind lbc_config_regs lbc_config_regs_chk #(.VENDOR_CODE(VENDOR_CODE),
    .DEVICE_CODE(DEVICE_CODE), .REVISION(REVISION)) u_chk (.clock, .rst_b, .cfg_read,
    .cfg_write, .cfg_device, .cfg_function, .cfg_offset, .cfg_byte_en, .cfg_wdata, .cfg_rdata,
    .cfg_hit, .shutdown_cycle, .cpu_init, .lpc_sync_error, .nmi, .unclaimed_cycle,
    .sec_devsel_l, .sec_start, .sub_devsel_oe, .sub_trdy_oe, .lpc_start, .route_busy);

// >>> lbc_far_side.sv
/* Far side of the router: a secondary target and the LPC end.
   Assumes the router outputs share the bench clock. */
`timescale 1ns/10ps
module lbc_far_side (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic claim,
    input wire logic sec_start,
    input wire logic lpc_start,
    output logic sec_devsel_l,
    output logic lpc_done
);
    logic [2:0] hold; // Cycles left with devsel driven
    logic [1:0] wait_n; // Cycles until the replay ends
    // Claim at once when told to, then release to the pull-up
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) hold <= 3'h0;
        else if (sec_start && claim && hold == 3'h0) hold <= 3'h7;
        else if (hold != 3'h0) hold <= hold - 3'h1;
    end
    assign sec_devsel_l = (hold == 3'h0);
    // End each LPC replay a few cycles after it starts
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) wait_n <= 2'h0;
        else if (lpc_start && wait_n == 2'h0) wait_n <= 2'h3;
        else if (wait_n != 2'h0) wait_n <= wait_n - 2'h1;
    end
    assign lpc_done = (wait_n == 2'h1);
endmodule

// >>> lbc_pkg.sv
/*
 * Package for the LPC bridge configuration register bank: offsets,
 * field positions, reset values and routing states.
 * Assumes nothing of its surroundings.
 */
package lbc_pkg;

    // Configuration offsets (dword aligned)
    localparam logic [7:0] LBC_OFS_IDENT = 8'h00;
    localparam logic [7:0] LBC_OFS_STSCMD = 8'h04;
    localparam logic [7:0] LBC_OFS_CLASSREV = 8'h08;
    localparam logic [7:0] LBC_OFS_HDRMISC = 8'h0c;
    localparam logic [7:0] LBC_OFS_SUBSYS = 8'h2c;
    localparam logic [7:0] LBC_OFS_IOCTL1 = 8'h40;
    localparam logic [7:0] LBC_OFS_SUBSYS_ALIAS = 8'h70;

    // Device number decoded on the primary bus
    localparam logic [4:0] LBC_DEV_NUM = 5'h01;
    localparam logic [2:0] LBC_FUNC_NUM = 3'h0;

    // Reset values
    localparam logic [31:0] LBC_STSCMD_RST = 32'h0220000f;
    localparam logic [31:0] LBC_HDRMISC_RST = 32'h00800000;
    localparam logic [31:0] LBC_SUBSYS_RST = 32'h00000000;
    localparam logic [7:0] LBC_IOCTL1_RST = 8'h00;
    localparam logic [23:0] LBC_CLASS_ISA = 24'h060100;

    // Field positions
    localparam int LBC_CMD_SPCYC_BIT = 3;
    localparam int LBC_IO1_NMI_BIT = 7;
    localparam int LBC_IO1_LPC_SYNC_ERROR_FLAG_BIT = 6;
    localparam int LBC_IO1_SECONDARY_FIRST_SUBTRACTIVE_BIT = 5;

    // Subtractive window: cycles after frame start a target may claim
    localparam logic [2:0] LBC_SUB_WINDOW = 3'h4;

    // Routing states for unclaimed host cycles
    typedef enum logic [1:0] {
        LBC_RT_IDLE = 2'b00,
        LBC_RT_SEC = 2'b01,
        LBC_RT_CLAIM = 2'b10,
        LBC_RT_LPC = 2'b11
    } lbc_route_t;

endpackage

// >>> lbc_router.sv
/*
 * Router for unclaimed host memory and IO cycles: tries the secondary
 * bus first when enabled, else goes straight to LPC.
 * Assumes secondary devsel is already synchronised to clock.
 */
`timescale 1ns/10ps
module lbc_router
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic unclaimed_cycle,
    input wire logic secondary_first,
    input wire logic sec_devsel_seen,
    input wire logic lpc_done,
    output logic sec_start,
    output logic sub_devsel_oe,
    output logic sub_trdy_oe,
    output logic lpc_start,
    output logic route_busy
);

    lbc_route_t state; // Current routing step
    logic [2:0] wait_cnt; // Cycles spent on the secondary bus

    // Routing sequence
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= LBC_RT_IDLE;
            wait_cnt <= 3'h0;
        end else begin
            unique case (state)
                LBC_RT_IDLE: begin
                    wait_cnt <= 3'h0;
                    if (unclaimed_cycle && secondary_first) begin
                        state <= LBC_RT_SEC;
                    end else if (unclaimed_cycle) begin
                        state <= LBC_RT_LPC;
                    end
                end
                LBC_RT_SEC: begin
                    if (sec_devsel_seen) begin
                        state <= LBC_RT_IDLE;
                    end else if (wait_cnt == LBC_SUB_WINDOW) begin
                        state <= LBC_RT_CLAIM;
                    end else begin
                        wait_cnt <= wait_cnt + 3'h1;
                    end
                end
                LBC_RT_CLAIM: begin
                    state <= LBC_RT_LPC;
                end
                LBC_RT_LPC: begin
                    if (lpc_done) begin
                        state <= LBC_RT_IDLE;
                    end
                end
            endcase
        end
    end

    // Strobes and claim enables
    assign sec_start = (state == LBC_RT_IDLE) && unclaimed_cycle && secondary_first;
    assign sub_devsel_oe = (state == LBC_RT_CLAIM);
    assign sub_trdy_oe = (state == LBC_RT_CLAIM);
    assign lpc_start = (state == LBC_RT_LPC);
    assign route_busy = (state != LBC_RT_IDLE);

endmodule

// >>> lbc_sync.sv
/*
 * Two-flop synchroniser for a level arriving from outside the clock.
 * Assumes a single clock and asynchronous active-low reset.
 */
`timescale 1ns/10ps
module lbc_sync (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);

    logic meta; // First stage, read only by the second

    // Two-stage capture
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule
